// >>> dbg_cmd_decoder.sv
// Command decoder of the on-chip debugger: takes command and operand
// bytes from the debug serial line and answers on the same line.
// Assumes the line's bit framing is handled outside; memories answer
// a read one cycle after the read strobe.
`timescale 1ns/10ps
module dbg_cmd_decoder #(
    parameter int PMEM_BYTES = dbg_cmd_pkg::PMEM_BYTES_DEFAULT
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // Received bytes of the debug serial line
    input wire logic rx_valid_i,
    input wire logic [7:0] rx_byte_i,
    // Answer bytes to the debug serial line
    output logic tx_valid_o,
    output logic [7:0] tx_byte_o,
    input wire logic tx_ready_i,
    // Device state
    input wire logic read_protect_option_i,
    input wire logic cpu_halted_i,
    input wire logic brk_return_i,
    input wire logic [15:0] runtime_count_i,
    input wire logic [2:0] op_len_i,
    output logic debug_mode_flag_o,
    // CPU instruction control
    output logic step_o,
    output logic stuff_o,
    output logic exec_valid_o,
    output logic exec_last_o,
    output logic [7:0] cpu_byte_o,
    // Program memory read port
    output logic pmem_rd_o,
    output logic [15:0] pmem_addr_o,
    input wire logic [7:0] pmem_data_i,
    // Data memory read port
    output logic dmem_rd_o,
    output logic [7:0] dmem_addr_o,
    input wire logic [7:0] dmem_data_i
);
    localparam logic [16:0] PMEM_N = 17'(PMEM_BYTES);

    dbg_cmd_pkg::state_type state_q;
    logic [7:0] cmd_q;
    logic [7:0] ctrl_q;
    logic [1:0] opnd_idx_q;
    logic [2:0] exec_left_q;
    logic [15:0] resp_q;
    logic resp_two_q;
    logic [16:0] count_q;
    logic [16:0] crc_issue_q;
    logic [16:0] crc_done_q;
    logic [15:0] crc_q;
    logic pmem_vld_q;
    logic [15:0] crc_next;
    logic dbg;
    logic ctrl_we;

    assign dbg = ctrl_q[dbg_cmd_pkg::CTRL_DBG_BIT];
    assign debug_mode_flag_o = ctrl_q[dbg_cmd_pkg::CTRL_DBG_BIT];

    // ----------------------------------------------------------------
    // Command gating
    // ----------------------------------------------------------------
    function automatic logic cmd_allowed(input logic [7:0] c, input logic d, input logic rp);
        case (c)
            dbg_cmd_pkg::CMD_RD_REV, dbg_cmd_pkg::CMD_RD_STAT,
            dbg_cmd_pkg::CMD_RD_CTRL, dbg_cmd_pkg::CMD_WR_CTRL: begin
                cmd_allowed = 1'b1;
            end
            dbg_cmd_pkg::CMD_RD_RTC: begin
                cmd_allowed = d;
            end
            dbg_cmd_pkg::CMD_RD_CRC: begin
                // Outside debug mode it answers the fixed value instead
                cmd_allowed = !rp;
            end
            dbg_cmd_pkg::CMD_RD_DMEM, dbg_cmd_pkg::CMD_STEP,
            dbg_cmd_pkg::CMD_STUFF, dbg_cmd_pkg::CMD_EXEC: begin
                cmd_allowed = d && !rp;
            end
            default: begin
                cmd_allowed = 1'b0;
            end
        endcase
    endfunction

    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {b, 8'h00};
        for (int i = 0; i < 8; i++) begin
            r = r[15] ? ((r << 1) ^ dbg_cmd_pkg::CRC_POLY) : (r << 1);
        end
        crc_byte = r;
    endfunction

    assign crc_next = crc_byte(crc_q, pmem_data_i);

    // ----------------------------------------------------------------
    // Debug control register
    // ----------------------------------------------------------------
    assign ctrl_we = (state_q == dbg_cmd_pkg::S_OPND) && rx_valid_i
        && (cmd_q == dbg_cmd_pkg::CMD_WR_CTRL);

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ctrl_q <= dbg_cmd_pkg::CTRL_RESET;
        end else begin
            if (ctrl_we) begin
                ctrl_q <= rx_byte_i;
                if (read_protect_option_i && dbg) begin
                    ctrl_q[dbg_cmd_pkg::CTRL_DBG_BIT] <= 1'b1;
                end
            end
            // Breakpoint entry wins over a clearing write in the same cycle
            if (brk_return_i) begin
                ctrl_q[dbg_cmd_pkg::CTRL_DBG_BIT] <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Command sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state_q <= dbg_cmd_pkg::S_IDLE;
            cmd_q <= 8'h00;
            opnd_idx_q <= 2'h0;
            exec_left_q <= 3'h0;
            resp_q <= 16'h0000;
            resp_two_q <= 1'b0;
            count_q <= 17'h00000;
            crc_issue_q <= 17'h00000;
            crc_done_q <= 17'h00000;
            crc_q <= dbg_cmd_pkg::CRC_INIT;
            tx_valid_o <= 1'b0;
            tx_byte_o <= 8'h00;
            step_o <= 1'b0;
            stuff_o <= 1'b0;
            exec_valid_o <= 1'b0;
            exec_last_o <= 1'b0;
            cpu_byte_o <= 8'h00;
            pmem_rd_o <= 1'b0;
            pmem_addr_o <= 16'h0000;
            pmem_vld_q <= 1'b0;
            dmem_rd_o <= 1'b0;
            dmem_addr_o <= 8'h00;
        end else begin
            step_o <= 1'b0;
            stuff_o <= 1'b0;
            exec_valid_o <= 1'b0;
            exec_last_o <= 1'b0;
            pmem_rd_o <= 1'b0;
            dmem_rd_o <= 1'b0;
            // Program memory data stands the cycle after the memory took the strobe
            pmem_vld_q <= pmem_rd_o;
            case (state_q)
                dbg_cmd_pkg::S_IDLE: begin
                    // Each received byte here is a command byte
                    if (rx_valid_i && cmd_allowed(rx_byte_i, dbg, read_protect_option_i)) begin
                        cmd_q <= rx_byte_i;
                        opnd_idx_q <= 2'h0;
                        exec_left_q <= 3'h0;
                        case (rx_byte_i)
                            dbg_cmd_pkg::CMD_RD_REV: begin
                                tx_valid_o <= 1'b1;
                                tx_byte_o <= dbg_cmd_pkg::REVISION[15:8];
                                resp_q <= dbg_cmd_pkg::REVISION;
                                resp_two_q <= 1'b1;
                                state_q <= dbg_cmd_pkg::S_SEND;
                            end
                            dbg_cmd_pkg::CMD_RD_STAT: begin
                                tx_valid_o <= 1'b1;
                                tx_byte_o <= 8'h00;
                                tx_byte_o[dbg_cmd_pkg::STAT_DBG_BIT] <= dbg;
                                tx_byte_o[dbg_cmd_pkg::STAT_HALT_BIT] <= cpu_halted_i;
                                tx_byte_o[dbg_cmd_pkg::STAT_PROT_BIT] <= read_protect_option_i;
                                resp_two_q <= 1'b0;
                                state_q <= dbg_cmd_pkg::S_SEND;
                            end
                            dbg_cmd_pkg::CMD_RD_RTC: begin
                                tx_valid_o <= 1'b1;
                                tx_byte_o <= runtime_count_i[15:8];
                                resp_q <= runtime_count_i;
                                resp_two_q <= 1'b1;
                                state_q <= dbg_cmd_pkg::S_SEND;
                            end
                            dbg_cmd_pkg::CMD_RD_CTRL: begin
                                tx_valid_o <= 1'b1;
                                tx_byte_o <= ctrl_q;
                                resp_two_q <= 1'b0;
                                state_q <= dbg_cmd_pkg::S_SEND;
                            end
                            dbg_cmd_pkg::CMD_RD_CRC: begin
                                if (!dbg) begin
                                    tx_valid_o <= 1'b1;
                                    tx_byte_o <= dbg_cmd_pkg::CRC_NOT_DEBUG[15:8];
                                    resp_q <= dbg_cmd_pkg::CRC_NOT_DEBUG;
                                    resp_two_q <= 1'b1;
                                    state_q <= dbg_cmd_pkg::S_SEND;
                                end else begin
                                    crc_q <= dbg_cmd_pkg::CRC_INIT;
                                    crc_issue_q <= 17'h00000;
                                    crc_done_q <= 17'h00000;
                                    state_q <= dbg_cmd_pkg::S_CRC;
                                end
                            end
                            dbg_cmd_pkg::CMD_STEP: begin
                                step_o <= 1'b1;
                            end
                            default: begin
                                state_q <= dbg_cmd_pkg::S_OPND;
                            end
                        endcase
                    end
                end
                dbg_cmd_pkg::S_OPND: begin
                    if (rx_valid_i) begin
                        opnd_idx_q <= opnd_idx_q + 2'h1;
                        case (cmd_q)
                            dbg_cmd_pkg::CMD_RD_DMEM: begin
                                // Address low, size high, size low
                                if (opnd_idx_q == 2'h0) begin
                                    dmem_addr_o <= rx_byte_i;
                                end else if (opnd_idx_q == 2'h1) begin
                                    count_q <= {1'b0, rx_byte_i, 8'h00};
                                end else begin
                                    if (count_q[15:8] == 8'h00 && rx_byte_i == 8'h00) begin
                                        count_q <= dbg_cmd_pkg::DMEM_FULL_COUNT;
                                    end else begin
                                        count_q <= {count_q[16:8], rx_byte_i};
                                    end
                                    state_q <= dbg_cmd_pkg::S_DMEM;
                                end
                            end
                            dbg_cmd_pkg::CMD_STUFF: begin
                                stuff_o <= 1'b1;
                                cpu_byte_o <= rx_byte_i;
                                state_q <= dbg_cmd_pkg::S_IDLE;
                            end
                            dbg_cmd_pkg::CMD_EXEC: begin
                                // Length comes from the opcode decoder
                                exec_valid_o <= 1'b1;
                                cpu_byte_o <= rx_byte_i;
                                // Operand index wraps at the fifth byte; the count marks the first
                                if (exec_left_q == 3'h0) begin
                                    exec_left_q <= (op_len_i == 3'h0) ? 3'h0 : op_len_i - 3'h1;
                                    if (op_len_i <= 3'h1) begin
                                        exec_last_o <= 1'b1;
                                        state_q <= dbg_cmd_pkg::S_IDLE;
                                    end
                                end else begin
                                    exec_left_q <= exec_left_q - 3'h1;
                                    if (exec_left_q == 3'h1) begin
                                        exec_last_o <= 1'b1;
                                        state_q <= dbg_cmd_pkg::S_IDLE;
                                    end
                                end
                            end
                            default: begin
                                // Control write stores through ctrl_we
                                state_q <= dbg_cmd_pkg::S_IDLE;
                            end
                        endcase
                    end
                end
                dbg_cmd_pkg::S_SEND: begin
                    if (tx_ready_i) begin
                        if (resp_two_q) begin
                            tx_byte_o <= resp_q[7:0];
                            resp_two_q <= 1'b0;
                        end else begin
                            tx_valid_o <= 1'b0;
                            state_q <= dbg_cmd_pkg::S_IDLE;
                        end
                    end
                end
                dbg_cmd_pkg::S_CRC: begin
                    // One read per cycle; reply after the last byte
                    if (crc_issue_q < PMEM_N) begin
                        pmem_rd_o <= 1'b1;
                        pmem_addr_o <= crc_issue_q[15:0];
                        crc_issue_q <= crc_issue_q + 17'h00001;
                    end
                    if (pmem_vld_q) begin
                        crc_q <= crc_next;
                        crc_done_q <= crc_done_q + 17'h00001;
                        if (crc_done_q == PMEM_N - 17'h00001) begin
                            tx_valid_o <= 1'b1;
                            tx_byte_o <= crc_next[15:8];
                            resp_q <= crc_next;
                            resp_two_q <= 1'b1;
                            state_q <= dbg_cmd_pkg::S_SEND;
                        end
                    end
                end
                dbg_cmd_pkg::S_DMEM: begin
                    dmem_rd_o <= 1'b1;
                    state_q <= dbg_cmd_pkg::S_DWAIT;
                end
                dbg_cmd_pkg::S_DWAIT: begin
                    // Memory takes the strobe at this edge; data stands one cycle later
                    if (!dmem_rd_o) begin
                        tx_valid_o <= 1'b1;
                        tx_byte_o <= dmem_data_i;
                        state_q <= dbg_cmd_pkg::S_DSEND;
                    end
                end
                dbg_cmd_pkg::S_DSEND: begin
                    if (tx_ready_i) begin
                        tx_valid_o <= 1'b0;
                        count_q <= count_q - 17'h00001;
                        dmem_addr_o <= dmem_addr_o + 8'h01;
                        state_q <= (count_q == 17'h00001) ? dbg_cmd_pkg::S_IDLE
                                                          : dbg_cmd_pkg::S_DMEM;
                    end
                end
                default: begin
                    state_q <= dbg_cmd_pkg::S_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    logic idle_cmd;
    assign idle_cmd = (state_q == dbg_cmd_pkg::S_IDLE) && rx_valid_i;

    a_step_gating: assert property (@(posedge clk_i) disable iff (srst_i)
        idle_cmd && rx_byte_i == dbg_cmd_pkg::CMD_STEP
        |=> step_o == ($past(dbg) && !$past(read_protect_option_i)))
        else $error("step pulse does not match gating");
    a_crc_ffff_reply: assert property (@(posedge clk_i) disable iff (srst_i)
        idle_cmd && rx_byte_i == dbg_cmd_pkg::CMD_RD_CRC && !dbg && !read_protect_option_i
        |=> tx_valid_o && tx_byte_o == 8'hFF)
        else $error("checksum outside debug mode is not FFFF");
    a_rev_always: assert property (@(posedge clk_i) disable iff (srst_i)
        idle_cmd && rx_byte_i == dbg_cmd_pkg::CMD_RD_REV
        |=> tx_valid_o ##0 tx_byte_o == dbg_cmd_pkg::REVISION[15:8])
        else $error("revision read not answered");
    a_rp_keep_debug: assert property (@(posedge clk_i) disable iff (srst_i)
        ctrl_we && read_protect_option_i && dbg |=> debug_mode_flag_o)
        else $error("protected write cleared debug mode");
    a_brk_enters_debug: assert property (@(posedge clk_i) disable iff (srst_i)
        brk_return_i |=> debug_mode_flag_o)
        else $error("breakpoint return did not set debug mode");
    a_unknown_dropped: assert property (@(posedge clk_i) disable iff (srst_i)
        idle_cmd && !cmd_allowed(rx_byte_i, dbg, read_protect_option_i)
        |=> state_q == dbg_cmd_pkg::S_IDLE && !tx_valid_o)
        else $error("unknown command not discarded");
    a_rp_blocks_dmem: assert property (@(posedge clk_i) disable iff (srst_i)
        idle_cmd && rx_byte_i == dbg_cmd_pkg::CMD_RD_DMEM && read_protect_option_i
        |=> state_q == dbg_cmd_pkg::S_IDLE [*2])
        else $error("block read accepted under protection");
    a_tx_held: assert property (@(posedge clk_i) disable iff (srst_i)
        tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_byte_o))
        else $error("answer byte dropped before taken");
    a_size_zero_full: assert property (@(posedge clk_i) disable iff (srst_i)
        state_q == dbg_cmd_pkg::S_OPND && rx_valid_i && cmd_q == dbg_cmd_pkg::CMD_RD_DMEM
        && opnd_idx_q == 2'h2 && count_q[15:8] == 8'h00 && rx_byte_i == 8'h00
        |=> count_q == dbg_cmd_pkg::DMEM_FULL_COUNT)
        else $error("size zero not taken as full count");

    c_crc_run: cover property (@(posedge clk_i) disable iff (srst_i)
        state_q == dbg_cmd_pkg::S_CRC ##1 state_q == dbg_cmd_pkg::S_SEND);
    c_dmem_byte: cover property (@(posedge clk_i) disable iff (srst_i)
        state_q == dbg_cmd_pkg::S_DSEND && tx_ready_i);
    c_exec_last: cover property (@(posedge clk_i) disable iff (srst_i) exec_last_o);
endmodule

// >>> dbg_cmd_decoder_pkgless_note.sv
// Holds no logic; every module of the decoder lives in dbg_cmd_decoder.sv.

// >>> dbg_cmd_pkg.sv
// Constants shared by the debugger command decoder.
// Assumes byte-level framing of the debug serial line is done elsewhere.
package dbg_cmd_pkg;
    // ----------------------------------------------------------------
    // Command codes
    // ----------------------------------------------------------------
    localparam logic [7:0] CMD_RD_REV = 8'h00;
    localparam logic [7:0] CMD_RD_STAT = 8'h02;
    localparam logic [7:0] CMD_RD_RTC = 8'h03;
    localparam logic [7:0] CMD_WR_CTRL = 8'h04;
    localparam logic [7:0] CMD_RD_CTRL = 8'h05;
    localparam logic [7:0] CMD_RD_DMEM = 8'h0D;
    localparam logic [7:0] CMD_RD_CRC = 8'h0E;
    localparam logic [7:0] CMD_STEP = 8'h10;
    localparam logic [7:0] CMD_STUFF = 8'h11;
    localparam logic [7:0] CMD_EXEC = 8'h12;
    // ----------------------------------------------------------------
    // Register fields and values
    // ----------------------------------------------------------------
    localparam int CTRL_DBG_BIT = 7;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int STAT_DBG_BIT = 7;
    localparam int STAT_HALT_BIT = 6;
    localparam int STAT_PROT_BIT = 5;
    // Arbitrary revision value
    localparam logic [15:0] REVISION = 16'h0101;
    // ----------------------------------------------------------------
    // Checksum and block read
    // ----------------------------------------------------------------
    localparam logic [15:0] CRC_POLY = 16'h1021;
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [15:0] CRC_NOT_DEBUG = 16'hFFFF;
    localparam logic [16:0] DMEM_FULL_COUNT = 17'h10000;
    localparam int PMEM_BYTES_DEFAULT = 65536;
    typedef enum logic [2:0] {
        S_IDLE, S_OPND, S_SEND, S_CRC, S_DMEM, S_DWAIT, S_DSEND
    } state_type;
endpackage

// >>> dbg_host_model.sv
// Far side of the decoder: host acceptance of answer bytes and memories.
// Assumes memories answer one cycle after the read strobe.
`timescale 1ns/10ps
module dbg_host_model (
    // Clock and control
    input wire logic clk_i,
    input wire logic stall_i,
    // Answer acceptance
    output logic tx_ready_o,
    // Memory ports
    input wire logic pmem_rd_i,
    input wire logic [15:0] pmem_addr_i,
    output logic [7:0] pmem_data_o,
    input wire logic dmem_rd_i,
    input wire logic [7:0] dmem_addr_i,
    output logic [7:0] dmem_data_o
);
    // Host takes answers on the same line, slowly on demand
    always_ff @(posedge clk_i) begin
        tx_ready_o <= stall_i ? ~tx_ready_o : 1'b1;
    end
    // Data flips when not freshly read so stale use shows up
    always_ff @(posedge clk_i) begin
        pmem_data_o <= pmem_rd_i ? (pmem_addr_i[7:0] ^ 8'h5A) : ~pmem_data_o;
        dmem_data_o <= dmem_rd_i ? (dmem_addr_i ^ 8'hA5) : ~dmem_data_o;
    end
endmodule

// >>> test_dbg_cmd_decoder.sv
// Self-checking bench for the debugger command decoder.
// Assumes dbg_host_model stands at the far side.
`timescale 1ns/10ps
module test_dbg_cmd_decoder;
    localparam int PMEM = 16;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic rx_valid_i = 1'b0;
    logic [7:0] rx_byte_i = 8'h00;
    logic prot = 1'b0;
    logic [2:0] op_len = 3'h3;
    logic brk = 1'b0;
    logic stall = 1'b0;
    logic tx_valid, tx_ready, dbg, step, stuff, xv, xl, prd, drd;
    logic [7:0] tx_byte, cpu_byte, pdat, ddat, daddr;
    logic [15:0] paddr;
    logic [7:0] last_cpu = 8'h00;
    int n_mismatch = 0;
    int num_checks = 0;
    int n_step = 0;
    int n_stuff = 0;
    int n_exec = 0;
    int n_last = 0;
    always #5 clk_i = ~clk_i;
    dbg_cmd_decoder #(.PMEM_BYTES(PMEM)) i_dbg_cmd_decoder (.clk_i(clk_i), .srst_i(srst_i),
        .rx_valid_i(rx_valid_i), .rx_byte_i(rx_byte_i), .tx_valid_o(tx_valid),
        .tx_byte_o(tx_byte), .tx_ready_i(tx_ready), .read_protect_option_i(prot),
        .cpu_halted_i(1'b1), .brk_return_i(brk), .runtime_count_i(16'h3C5A),
        .op_len_i(op_len), .debug_mode_flag_o(dbg), .step_o(step), .stuff_o(stuff),
        .exec_valid_o(xv), .exec_last_o(xl), .cpu_byte_o(cpu_byte), .pmem_rd_o(prd),
        .pmem_addr_o(paddr), .pmem_data_i(pdat), .dmem_rd_o(drd), .dmem_addr_o(daddr),
        .dmem_data_i(ddat));
    dbg_host_model i_dbg_host_model (.clk_i(clk_i), .stall_i(stall), .tx_ready_o(tx_ready),
        .pmem_rd_i(prd), .pmem_addr_i(paddr), .pmem_data_o(pdat), .dmem_rd_i(drd),
        .dmem_addr_i(daddr), .dmem_data_o(ddat));
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    always @(posedge clk_i) begin
        if (step === 1'b1) n_step++;
        if (stuff === 1'b1) n_stuff++;
        if (xv === 1'b1) n_exec++;
        if (xl === 1'b1) n_last++;
        if ((stuff | xv) === 1'b1) last_cpu = cpu_byte;
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic send(input logic [7:0] b);
        @(posedge clk_i);
        rx_valid_i <= 1'b1;
        rx_byte_i <= b;
        @(posedge clk_i);
        rx_valid_i <= 1'b0;
    endtask
    // Waits for a taken answer byte; a missing one fails the valid bit
    task automatic get(input string what, input logic [7:0] exp);
        for (int k = 0; k < 200; k++) begin
            @(posedge clk_i);
            if ((tx_valid & tx_ready) === 1'b1) break;
        end
        check(what, {7'h0, tx_valid & tx_ready, tx_byte}, {8'h01, exp});
    endtask
    task automatic quiet(input string what);
        logic seen;
        seen = 1'b0;
        repeat (8) begin
            @(posedge clk_i);
            seen |= (tx_valid !== 1'b0);
        end
        check(what, {15'h0, seen}, 16'h0);
    endtask
    function automatic logic [15:0] crc_exp();
        logic [15:0] c;
        logic [7:0] d;
        c = 16'hFFFF;
        for (int a = 0; a < PMEM; a++) begin
            d = a[7:0] ^ 8'h5A;
            for (int b = 7; b >= 0; b--) begin
                c = {c[14:0], 1'b0} ^ ((c[15] ^ d[b]) ? 16'h1021 : 16'h0000);
            end
        end
        return c;
    endfunction
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_normal();
        send(8'h00);
        get("rev hi", 8'h01);
        get("rev lo", 8'h01);
        send(8'h02);
        get("status", 8'h40);
        send(8'h05);
        get("ctrl", 8'h00);
        send(8'h03);
        quiet("runtime off");
        send(8'h10);
        quiet("step off");
        send(8'h7F);
        quiet("unknown");
        send(8'h0E);
        get("crc off hi", 8'hFF);
        get("crc off lo", 8'hFF);
    endtask
    task automatic t_debug();
        logic [15:0] c;
        c = crc_exp();
        send(8'h04);
        send(8'h80);
        send(8'h05);
        get("ctrl set", 8'h80);
        send(8'h03);
        get("runtime hi", 8'h3C);
        get("runtime lo", 8'h5A);
        stall <= 1'b1;
        send(8'h0E);
        get("crc hi", c[15:8]);
        get("crc lo", c[7:0]);
        stall <= 1'b0;
        send(8'h0D);
        send(8'hFE);
        send(8'h00);
        send(8'h03);
        get("blk 0", 8'h5B);
        get("blk 1", 8'h5A);
        get("blk 2", 8'hA5);
        quiet("blk end");
    endtask
    task automatic t_cpu();
        send(8'h10);
        send(8'h11);
        send(8'h3E);
        repeat (3) @(posedge clk_i);
        check("step", n_step[15:0], 16'h1);
        check("stuff", {n_stuff[7:0], last_cpu}, 16'h013E);
        send(8'h12);
        send(8'hAA);
        send(8'hBB);
        send(8'hCC);
        repeat (3) @(posedge clk_i);
        check("exec", {n_exec[3:0], n_last[3:0], last_cpu}, 16'h31CC);
        op_len <= 3'h5;
        send(8'h12);
        for (int k = 1; k <= 5; k++) begin
            send(8'(k));
        end
        repeat (3) @(posedge clk_i);
        check("exec5", {n_exec[3:0], n_last[3:0], last_cpu}, 16'h8205);
        op_len <= 3'h1;
        send(8'h12);
        send(8'hDD);
        repeat (3) @(posedge clk_i);
        check("exec1", {n_exec[3:0], n_last[3:0], last_cpu}, 16'h93DD);
    endtask
    task automatic t_protect();
        prot <= 1'b1;
        send(8'h02);
        get("status rp", 8'hE0);
        send(8'h0E);
        quiet("crc rp");
        send(8'h0D);
        quiet("blk rp");
        send(8'h10);
        repeat (3) @(posedge clk_i);
        check("step rp", n_step[15:0], 16'h1);
        send(8'h04);
        send(8'h00);
        send(8'h05);
        get("ctrl rp", 8'h80);
        prot <= 1'b0;
        send(8'h04);
        send(8'h00);
        send(8'h02);
        get("status clr", 8'h40);
        @(posedge clk_i);
        brk <= 1'b1;
        @(posedge clk_i);
        brk <= 1'b0;
        send(8'h02);
        get("status brk", 8'hC0);
    endtask
    // Full-size read is cut short by a reset in mid-transfer
    task automatic t_full_reset();
        send(8'h0D);
        send(8'h00);
        send(8'h00);
        send(8'h00);
        get("full 0", 8'hA5);
        get("full 1", 8'hA4);
        srst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        srst_i <= 1'b0;
        quiet("reset quiet");
        send(8'h02);
        get("status reset", 8'h40);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        #50000;
        n_mismatch++;
        report_and_stop();
    end
    initial begin
        repeat (5) @(posedge clk_i);
        srst_i <= 1'b0;
        t_normal();
        t_debug();
        t_cpu();
        t_protect();
        t_full_reset();
        report_and_stop();
    end
endmodule
